//--- verilog/flash_upc_cpu.sv
// CPU-side controller: AXI4-Lite registers driving program, read and lock
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "flash_upc_params.svh"
module flash_upc_cpu (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// AXI4-Lite write address and data
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [3:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	// AXI4-Lite write response
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// AXI4-Lite read
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [3:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// Flash device link
	flash_upc_if.cpu_end LINK
);
	import flash_upc_pkg::*;

	// ==========================================================
	// Bus slave state
	logic aw_have_q;
	logic [3:0] aw_addr_q;
	logic w_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	// Controller registers
	logic [15:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rd_byte_q;
	op_e op_q;
	seq_state_e state_q;
	seq_state_e state_d;

	wire do_write;
	wire wr_mapped;
	wire rd_mapped;
	wire busy;
	wire go;
	wire [31:0] status_word;
	wire [31:0] read_word;

	// ==========================================================
	// Decode
	// Address and data are parked, so they may arrive in either order
	assign AWREADY = !aw_have_q && !bvalid_q;
	assign WREADY = !w_have_q && !bvalid_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wr_mapped = (aw_addr_q == `REG_CTRL) || (aw_addr_q == `REG_ADDR)
		|| (aw_addr_q == `REG_WDATA) || (aw_addr_q == `REG_STATUS);
	assign rd_mapped = (ARADDR == `REG_CTRL) || (ARADDR == `REG_ADDR)
		|| (ARADDR == `REG_WDATA) || (ARADDR == `REG_STATUS);
	assign busy = (state_q != ST_IDLE);
	// A start while busy is dropped; the bus still answers OKAY
	assign go = do_write && (aw_addr_q == `REG_CTRL) && w_strb_q[0] && !busy
		&& (w_data_q[1:0] != OP_NONE);
	assign status_word = {8'h00, LINK.byte_count, rd_byte_q, 5'h00, LINK.op_fail,
		LINK.locked, busy};
	assign read_word = (ARADDR == `REG_CTRL) ? {30'h0, op_q} :
		(ARADDR == `REG_ADDR) ? {16'h0, addr_q} :
		(ARADDR == `REG_WDATA) ? {24'h0, wdata_q} :
		(ARADDR == `REG_STATUS) ? status_word : 32'h0;

	// ==========================================================
	// Write channel
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `AXI_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_have_q <= 1'b1;
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
			end else if (BREADY && bvalid_q) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Address and data registers honour byte strobes; ignored while busy
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			op_q <= OP_NONE;
		end else begin
			if (do_write && !busy && (aw_addr_q == `REG_ADDR)) begin
				if (w_strb_q[0])
					addr_q[7:0] <= w_data_q[7:0];
				if (w_strb_q[1])
					addr_q[15:8] <= w_data_q[15:8];
			end
			if (do_write && !busy && (aw_addr_q == `REG_WDATA) && w_strb_q[0])
				wdata_q <= w_data_q[7:0];
			if (go)
				op_q <= op_e'(w_data_q[1:0]);
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `AXI_OKAY;
		end else if (ARVALID && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= read_word;
			rresp_q <= rd_mapped ? `AXI_OKAY : `AXI_SLVERR;
		end else if (RREADY && rvalid_q) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Sequencer: one device step per state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (go && (w_data_q[1:0] == OP_READ))
					state_d = ST_ACCESS;
				else if (go)
					state_d = ST_KEY;
			end
			ST_KEY: state_d = (op_q == OP_LOCK) ? ST_CMD : ST_SECH;
			ST_SECH: state_d = ST_SECL;
			ST_SECL: state_d = ST_CMD;
			ST_CMD: state_d = (op_q == OP_LOCK) ? ST_NOP : ST_ACCESS;
			ST_ACCESS: state_d = ST_WAIT;
			ST_WAIT: begin
				if (LINK.mem_ack)
					state_d = (op_q == OP_READ) ? ST_IDLE : ST_NOP;
			end
			ST_NOP: state_d = ST_LEAVE;
			ST_LEAVE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Read byte is captured when the device answers
	always_ff @(posedge CLOCK) begin
		if (RST)
			rd_byte_q <= 8'h00;
		else if ((state_q == ST_WAIT) && LINK.mem_ack && (op_q == OP_READ))
			rd_byte_q <= LINK.mem_rdata;
	end

	// ==========================================================
	// Link drive
	// Sector registers are reloaded on every program, so the budget
	// of 128 bytes can never run out under this controller
	assign LINK.sfr_wr = (state_q == ST_KEY) || (state_q == ST_SECH)
		|| (state_q == ST_SECL) || (state_q == ST_CMD) || (state_q == ST_LEAVE);
	assign LINK.sfr_sel = (state_q == ST_SECH) ? SEL_SECH :
		(state_q == ST_SECL) ? SEL_SECL :
		(state_q == ST_CMD) ? SEL_CMD : SEL_KEY;
	assign LINK.sfr_wdata = (state_q == ST_KEY) ? `KEY_ENTER :
		(state_q == ST_SECH) ? addr_q[15:8] :
		(state_q == ST_SECL) ? {addr_q[7], 7'h00} :
		(state_q == ST_CMD) ? ((op_q == OP_LOCK) ? `CMD_LOCK : `CMD_PROGRAM) :
		`KEY_LEAVE;
	assign LINK.mem_req = (state_q == ST_ACCESS);
	assign LINK.mem_we = (op_q == OP_PROGRAM);
	assign LINK.mem_addr_hi = addr_q[15:8];
	assign LINK.mem_addr_lo = addr_q[7:0];
	assign LINK.mem_wdata = wdata_q;

	// ==========================================================
	// Bus outputs
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = !rvalid_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
endmodule

//--- verilog/flash_upc_params.svh
// Constants of the user-mode flash program controller
`ifndef FLASH_UPC_PARAMS_SVH
`define FLASH_UPC_PARAMS_SVH
// ==========================================================
// Array organisation
`define SECTOR_BYTES 8'h80
`define SECTOR_COUNT 512
`define FLASH_BYTES 65536
`define FLASH_LAST_ADDR 16'hffff
`define ERASED_BYTE 8'hff
// ==========================================================
// Key, command codes and reset values of device registers
`define KEY_ENTER 8'ha5
`define KEY_LEAVE 8'h00
`define CMD_PROGRAM 8'h51
`define CMD_LOCK 8'h61
`define LOCK_NIBBLE 4'h6
`define SFR_RESET 8'h00
// ==========================================================
// Controller register offsets (byte addresses, one word each) and AXI response codes
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_STATUS 4'hc
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

//--- verilog/flash_upc_pkg.sv
// Types shared by both ends of the flash program link
package flash_upc_pkg;
	// Which device register a special-register write targets
	typedef enum logic [1:0] {
		SEL_KEY = 2'h0,
		SEL_SECH = 2'h1,
		SEL_SECL = 2'h2,
		SEL_CMD = 2'h3
	} sfr_sel_e;
	// Operation requested of the controller
	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_PROGRAM = 2'h1,
		OP_READ = 2'h2,
		OP_LOCK = 2'h3
	} op_e;
	// Controller sequencer states
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_KEY = 9'h002,
		ST_SECH = 9'h004,
		ST_SECL = 9'h008,
		ST_CMD = 9'h010,
		ST_ACCESS = 9'h020,
		ST_WAIT = 9'h040,
		ST_NOP = 9'h080,
		ST_LEAVE = 9'h100
	} seq_state_e;
endpackage

//--- verilog/flash_upc_if.sv
// Link between the CPU-side controller and the flash device
`timescale 1ns/1ps
interface flash_upc_if;
	import flash_upc_pkg::*;
	// Special-register writes
	logic sfr_wr;
	sfr_sel_e sfr_sel;
	logic [7:0] sfr_wdata;
	// Table load/store through the working register pair
	logic mem_req;
	logic mem_we;
	logic [7:0] mem_addr_hi;
	logic [7:0] mem_addr_lo;
	logic [7:0] mem_wdata;
	logic mem_ack;
	logic [7:0] mem_rdata;
	// Device state seen by the CPU
	logic locked;
	logic op_fail;
	logic [7:0] byte_count;
	modport device_end (
		input sfr_wr, sfr_sel, sfr_wdata, mem_req, mem_we, mem_addr_hi, mem_addr_lo,
		input mem_wdata,
		output mem_ack, mem_rdata, locked, op_fail, byte_count
	);
	modport cpu_end (
		output sfr_wr, sfr_sel, sfr_wdata, mem_req, mem_we, mem_addr_hi, mem_addr_lo,
		output mem_wdata,
		input mem_ack, mem_rdata, locked, op_fail, byte_count
	);
endinterface

//--- verilog/flash_upc_device.sv
// Flash array with user-mode program, read and hard lock control
//
// Operation
// - program single bytes, only into erased cells
// - software loads sector registers before programming
// - store via register pair starts a write
// - at most 128 bytes per sector setting
// - software writes enable key before commands
// - software arms programming with program command
// - software clears enable key when done
// - load via register pair reads, no key
// - upper nibble 0110 in command sets lock
// - locked array refuses every user write
// - only tool chip erase clears lock
// - software sets lock with key then command
// - software places dummy cycle after start
// - array is 512 sectors of 128 bytes
`timescale 1ns/1ps
`include "flash_upc_params.svh"
module flash_upc_device (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// CPU link
	flash_upc_if.device_end LINK,
	// Tool program mode and stored lock state
	input wire logic TOOL_CHIP_ERASE,
	input wire logic NV_LOCK,
	// Device state
	output logic ERASE_BUSY,
	output logic HARD_LOCK
);
	import flash_upc_pkg::*;

	// ==========================================================
	// Storage
	// One byte per cell; 512 sectors of 128 bytes
	logic [7:0] flash_mem [0:`FLASH_BYTES-1];

	logic [7:0] key_q;
	logic [7:0] sech_q;
	logic [7:0] secl_q;
	logic [7:0] cmd_q;
	logic lock_q;
	logic fail_q;
	logic [7:0] count_q;
	logic ack_q;
	logic [7:0] rdata_q;
	logic erase_q;
	logic [15:0] erase_addr_q;

	// ==========================================================
	// Decode of the CPU link
	wire [15:0] mem_addr;
	wire [8:0] target_sector;
	wire [8:0] set_sector;
	wire key_ok;
	wire prog_armed;
	wire in_sector;
	wire budget_left;
	wire cell_blank;
	wire store_req;
	wire store_ok;
	wire store_bad;
	wire cmd_write;
	wire cmd_accept;
	wire lock_cmd;
	wire sector_reload;
	wire erase_start;
	wire erase_last;

	// Address comes from the upper and lower working registers
	assign mem_addr = {LINK.mem_addr_hi, LINK.mem_addr_lo};
	// Sector number is the address bits above the 128-byte offset
	assign target_sector = mem_addr[15:7];
	assign set_sector = {sech_q, secl_q[7]};
	assign key_ok = (key_q == `KEY_ENTER);
	assign prog_armed = key_ok && (cmd_q == `CMD_PROGRAM);
	assign in_sector = (target_sector == set_sector);
	assign budget_left = (count_q < `SECTOR_BYTES);
	// Programming can only clear bits, so only a blank cell is written
	assign cell_blank = (flash_mem[mem_addr] == `ERASED_BYTE);
	assign store_req = LINK.mem_req && LINK.mem_we;
	// Every guard must pass, otherwise the array is left untouched
	assign store_ok = store_req && prog_armed && !lock_q && !erase_q
		&& in_sector && budget_left && cell_blank;
	assign store_bad = store_req && !store_ok;
	assign cmd_write = LINK.sfr_wr && (LINK.sfr_sel == SEL_CMD);
	// A command written without the key does not even reach the register
	assign cmd_accept = cmd_write && key_ok;
	assign lock_cmd = cmd_accept && (LINK.sfr_wdata[7:4] == `LOCK_NIBBLE);
	assign sector_reload = LINK.sfr_wr && ((LINK.sfr_sel == SEL_SECH)
		|| (LINK.sfr_sel == SEL_SECL));
	assign erase_start = TOOL_CHIP_ERASE && !erase_q;
	assign erase_last = erase_q && (erase_addr_q == `FLASH_LAST_ADDR);

	// ==========================================================
	// Special registers
	// Key and sector registers take any value; software is trusted there
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			key_q <= `SFR_RESET;
			sech_q <= `SFR_RESET;
			secl_q <= `SFR_RESET;
		end else if (LINK.sfr_wr) begin
			if (LINK.sfr_sel == SEL_KEY)
				key_q <= LINK.sfr_wdata;
			if (LINK.sfr_sel == SEL_SECH)
				sech_q <= LINK.sfr_wdata;
			if (LINK.sfr_sel == SEL_SECL)
				secl_q <= LINK.sfr_wdata;
		end
	end

	// Command register only loads while the key is present
	always_ff @(posedge CLOCK) begin
		if (RST)
			cmd_q <= `SFR_RESET;
		else if (cmd_accept)
			cmd_q <= LINK.sfr_wdata;
	end

	// ==========================================================
	// Hard lock
	// The lock lives in nonvolatile cells, so reset reloads the stored
	// copy instead of clearing it; a lock command beats an erase start
	always_ff @(posedge CLOCK) begin
		if (RST)
			lock_q <= NV_LOCK;
		else if (lock_cmd)
			lock_q <= 1'b1;
		else if (erase_start)
			lock_q <= 1'b0;
	end

	// ==========================================================
	// Byte budget per sector setting
	// Reloading either sector register opens a fresh budget of 128
	always_ff @(posedge CLOCK) begin
		if (RST)
			count_q <= 8'h00;
		else if (sector_reload)
			count_q <= 8'h00;
		else if (store_ok)
			count_q <= count_q + 8'h01;
	end

	// ==========================================================
	// Refusal flag
	// Set by any refused store, cleared by a command write; set wins
	always_ff @(posedge CLOCK) begin
		if (RST)
			fail_q <= 1'b0;
		else if (store_bad)
			fail_q <= 1'b1;
		else if (cmd_write)
			fail_q <= 1'b0;
	end

	// ==========================================================
	// Load and store answers
	// Each request is answered one cycle later; reads need no key
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= LINK.mem_req;
			if (LINK.mem_req && !LINK.mem_we)
				rdata_q <= flash_mem[mem_addr];
		end
	end

	// ==========================================================
	// Tool-mode chip erase
	// Walks the array one cell per clock; stores are refused meanwhile
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			erase_q <= 1'b0;
			erase_addr_q <= 16'h0000;
		end else if (erase_start) begin
			erase_q <= 1'b1;
			erase_addr_q <= 16'h0000;
		end else if (erase_q) begin
			erase_q <= !erase_last;
			erase_addr_q <= erase_addr_q + 16'h0001;
		end
	end

	// ==========================================================
	// Array write port
	// One byte per store; the array itself has no reset
	always_ff @(posedge CLOCK) begin
		if (erase_q)
			flash_mem[erase_addr_q] <= `ERASED_BYTE;
		else if (store_ok)
			flash_mem[mem_addr] <= LINK.mem_wdata;
	end

	// ==========================================================
	// Outputs
	assign LINK.mem_ack = ack_q;
	assign LINK.mem_rdata = rdata_q;
	assign LINK.locked = lock_q;
	assign LINK.op_fail = fail_q;
	assign LINK.byte_count = count_q;
	assign ERASE_BUSY = erase_q;
	assign HARD_LOCK = lock_q;
endmodule

//--- bench/flash_upc_checker.sv
// Concurrent checks on the link between controller and flash device
`timescale 1ns/1ps
`include "flash_upc_params.svh"
module flash_upc_checker (
	// Clock, reset and device state
	input logic CLOCK,
	input logic RST,
	input logic ERASE_BUSY,
	// Link signals
	input logic sfr_wr,
	input flash_upc_pkg::sfr_sel_e sfr_sel,
	input logic [7:0] sfr_wdata,
	input logic mem_req,
	input logic mem_we,
	input logic [7:0] mem_addr_hi,
	input logic [7:0] mem_addr_lo,
	input logic mem_ack,
	input logic locked,
	input logic op_fail,
	input logic [7:0] byte_count
);
	import flash_upc_pkg::*;
	// ==========================================================
	// Shadow key and sector, so refusals are judged from the link alone
	logic [7:0] key_q, sech_q, secl_q;
	wire store_req = mem_req && mem_we;
	wire cmd_wr = sfr_wr && sfr_sel == SEL_CMD;
	wire sec_wr = sfr_wr && (sfr_sel == SEL_SECH || sfr_sel == SEL_SECL);
	always_ff @(posedge CLOCK) begin
		key_q <= RST ? `SFR_RESET : (sfr_wr && sfr_sel == SEL_KEY) ? sfr_wdata : key_q;
		sech_q <= RST ? `SFR_RESET : (sfr_wr && sfr_sel == SEL_SECH) ? sfr_wdata : sech_q;
		secl_q <= RST ? `SFR_RESET : (sfr_wr && sfr_sel == SEL_SECL) ? sfr_wdata : secl_q;
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	ack_latency_a: assert property (mem_req |=> mem_ack)
		else $error("request not answered in one cycle");
	ack_cause_a: assert property (mem_ack |-> $past(mem_req))
		else $error("answer without request");
	read_keyless_a: assert property (mem_req && !mem_we |=> mem_ack && $stable(byte_count))
		else $error("load disturbed count or not answered");
	lock_set_a: assert property (cmd_wr && sfr_wdata[7:4] == `LOCK_NIBBLE
		&& key_q == `KEY_ENTER |=> locked) else $error("lock command did not lock");
	lock_clear_a: assert property ($fell(locked) |-> ERASE_BUSY)
		else $error("lock released without chip erase");
	locked_refuse_a: assert property (store_req && locked |=> op_fail && $stable(byte_count))
		else $error("store accepted while locked");
	nokey_refuse_a: assert property (store_req && key_q != `KEY_ENTER |=> op_fail)
		else $error("store accepted without key");
	sector_refuse_a: assert property (store_req
		&& {mem_addr_hi, mem_addr_lo[7]} != {sech_q, secl_q[7]} |=> op_fail)
		else $error("store outside loaded sector accepted");
	count_limit_a: assert property (byte_count <= `SECTOR_BYTES)
		else $error("byte count above sector size");
	count_clear_a: assert property (sec_wr && !mem_req |=> byte_count == 8'h00)
		else $error("sector load did not clear count");
	count_step_a: assert property ($changed(byte_count) && !$past(sfr_wr) && !ERASE_BUSY
		|-> byte_count == $past(byte_count) + 8'h01 && $past(store_req))
		else $error("count moved by other than one store");
endmodule

//--- bench/tb.sv
// Self-checking bench for the flash program controller and device
`timescale 1ns/1ps
`include "flash_upc_params.svh"
module tb;
	import flash_upc_pkg::*;
	// ==========================================================
	// Nets, counters and the bench model
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, erase_busy, hard_lock;
	logic [1:0] bresp, rresp, resp, rr;
	logic [31:0] rdata, st;
	logic tool_chip_erase = 1'b0;
	logic nv_lock = 1'b1;
	int failures = 0;
	int n_compared = 0;
	int seed = 32'h4caf;
	logic [7:0] model_mem [int];
	logic m_lock, m_fail;
	logic [7:0] m_count, m_rd, d;
	logic [15:0] a;
	logic [15:0] done_q [$];
	flash_upc_if link ();
	flash_upc_device i_flash_upc_device (.CLOCK(clock), .RST(rst), .LINK(link),
		.TOOL_CHIP_ERASE(tool_chip_erase), .NV_LOCK(nv_lock), .ERASE_BUSY(erase_busy),
		.HARD_LOCK(hard_lock));
	flash_upc_cpu i_flash_upc_cpu (.CLOCK(clock), .RST(rst), .AWVALID(awvalid),
		.AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
		.WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
		.ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
		.RRESP(rresp), .LINK(link));
	flash_upc_checker i_flash_upc_checker (.CLOCK(clock), .RST(rst), .ERASE_BUSY(erase_busy),
		.sfr_wr(link.sfr_wr), .sfr_sel(link.sfr_sel), .sfr_wdata(link.sfr_wdata),
		.mem_req(link.mem_req), .mem_we(link.mem_we), .mem_addr_hi(link.mem_addr_hi),
		.mem_addr_lo(link.mem_addr_lo), .mem_ack(link.mem_ack), .locked(link.locked),
		.op_fail(link.op_fail), .byte_count(link.byte_count));
	// 20 MHz clock
	initial begin
		forever #25 clock = ~clock;
	end
	// ==========================================================
	// Comparison, verdict and bus tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Both write channels offered at once, each dropped at the edge that takes it
	task automatic axi_write(input logic [3:0] ad, input logic [31:0] dat, output logic [1:0] r);
		@(posedge clock);
		awaddr <= ad;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [3:0] ad, output logic [31:0] dat);
		@(posedge clock);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		dat = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	function automatic logic [7:0] rd_model(input logic [15:0] ad);
		return model_mem.exists(ad) ? model_mem[ad] : `ERASED_BYTE;
	endfunction
	// Runs one operation, polls until idle, then moves the model on
	task automatic run_op(input logic [1:0] op, input logic [15:0] ad, input logic [7:0] dat);
		int n;
		axi_write(`REG_ADDR, {16'h0000, ad}, resp);
		axi_write(`REG_WDATA, {24'h000000, dat}, resp);
		axi_write(`REG_CTRL, {30'h00000000, op}, resp);
		n = 0;
		do begin
			axi_read(`REG_STATUS, st);
			n++;
		end while (st[0] !== 1'b0 && n < 50);
		// A controller that never goes idle is a failure, not a silent pass
		if (st[0] !== 1'b0) begin
			failures++;
			test_done();
		end
		if (op == 2'h1) begin
			m_fail = m_lock || rd_model(ad) !== `ERASED_BYTE;
			if (!m_fail) model_mem[ad] = dat;
			m_count = m_fail ? 8'h00 : 8'h01;
		end
		if (op == 2'h2) m_rd = rd_model(ad);
		if (op == 2'h3) m_lock = 1'b1;
		if (op == 2'h3) m_fail = 1'b0;
	endtask
	function automatic logic [31:0] exp_st();
		return {8'h00, m_count, m_rd, 5'h00, m_fail, m_lock, 1'b0};
	endfunction
	// ==========================================================
	// Main sequence: lock kept over reset, erase, program, lock, reset
	initial begin
		m_lock = 1'b0;
		m_fail = 1'b0;
		m_count = 8'h00;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		axi_read(`REG_STATUS, st);
		check("strap lock", st[1], 1'b1);
		@(posedge clock);
		tool_chip_erase <= 1'b1;
		nv_lock <= 1'b0;
		@(posedge clock);
		tool_chip_erase <= 1'b0;
		repeat (2) @(posedge clock);
		while (erase_busy !== 1'b0) @(posedge clock);
		run_op(2'h2, 16'h1234, 8'h00);
		check("erased read", st, exp_st());
		// Unaligned offsets are unmapped: error response, nothing changes
		axi_write(4'h2, 32'h00000003, resp);
		check("unmapped write", resp, `AXI_SLVERR);
		axi_read(4'h2, st);
		check("unmapped read", st, 32'h00000000);
		check("unmapped rresp", rr, `AXI_SLVERR);
		axi_read(`REG_STATUS, st);
		check("after unmapped", st, exp_st());
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 16'h0000 : (i == 1) ? `FLASH_LAST_ADDR : 16'($random(seed));
			d = 8'($random(seed)) & 8'h7f;
			run_op(2'h1, a, d);
			check("program", st, exp_st());
			check("write resp", resp, `AXI_OKAY);
			done_q.push_back(a);
			run_op(2'h2, a, 8'h00);
			check("read back", st, exp_st());
			check("read resp", rr, `AXI_OKAY);
			run_op(2'h1, a, ~d);
			check("reprogram refused", st, exp_st());
		end
		run_op(2'h3, 16'h0000, 8'h00);
		check("lock", st, exp_st());
		check("lock pin", hard_lock, 1'b1);
		run_op(2'h1, 16'h4321, 8'h12);
		check("locked program", st, exp_st());
		@(posedge clock);
		nv_lock <= 1'b1;
		rst <= 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		m_fail = 1'b0;
		m_count = 8'h00;
		done_q.push_back(16'h4321);
		foreach (done_q[k]) begin
			run_op(2'h2, done_q[k], 8'h00);
			check("final read", st, exp_st());
		end
		test_done();
	end
	// Watchdog: the run needs about 70000 cycles
	initial begin
		#5000000;
		failures++;
		test_done();
	end
endmodule
